/* File: src/dual_half_timer_map.svh */
// Register offsets, field positions, reset values and counts of the dual half timer.
`ifndef DUAL_HALF_TIMER_MAP_SVH
`define DUAL_HALF_TIMER_MAP_SVH

// Register byte offsets on the register bus.
`define DHT_CTRL_OFS        4'h0
`define DHT_COUNT_OFS       4'h4
`define DHT_COMPARE_OFS     4'h8
`define DHT_STATUS_OFS      4'hC

// Fields of timer_control_reg.
`define DHT_CTRL_W          11
`define DHT_CTRL_RST        11'h400
`define DHT_MODE16_BIT      0
`define DHT_LEVEL_LSB       1
`define DHT_TOGGLE_LSB      3
`define DHT_LO_CLKSEL_LSB   5
`define DHT_HI_CLKSEL_LSB   7
`define DHT_LO_OVF16_BIT    9
`define DHT_ACTIVE_BIT      10

// Fields of the status register; bit LSB is the lower half, LSB+1 the upper.
`define DHT_STAT_OVF_LSB    0
`define DHT_STAT_CMF_LSB    2
`define DHT_STAT_IRQ_LSB    4
`define DHT_STAT_PIN_LSB    6

// Counting clock selections.
`define DHT_CLK_STOP        2'h0
`define DHT_CLK_SYS         2'h1
`define DHT_CLK_W4          2'h2

// Pulse widths in watch-clock periods when the watch clock divided by four counts.
`define DHT_EVT_W_PERIODS   2'h2
`define DHT_IRQ_W_PERIODS   1'h1

// Counter reset values and the top count of a half.
`define DHT_COUNT_RST       8'h00
`define DHT_COMPARE_RST     8'hFF
`define DHT_HALF_MAX        8'hFF

// Bus responses.
`define DHT_RESP_OKAY       2'h0
`define DHT_RESP_SLVERR     2'h2

`endif

/* File: src/dual_half_timer_pkg.sv */
// Types shared by the dual half timer modules.
`include "dual_half_timer_map.svh"
package dual_half_timer_pkg;
    // One 8-bit counter half.
    typedef logic [7:0] half_t;
    // Counting clock selection of one half.
    typedef enum logic [1:0] {
        CLK_STOP = `DHT_CLK_STOP,
        CLK_SYS  = `DHT_CLK_SYS,
        CLK_W4   = `DHT_CLK_W4
    } clk_sel_t;
endpackage

/* File: src/half_counter.sv */
// One 8-bit counter half with its compare value, overflow and match events.
`timescale 1ns/1ps
`default_nettype none
`include "dual_half_timer_map.svh"
module half_counter (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    input  wire logic                       tick,
    input  wire logic                       run,
    input  wire logic                       cnt_wr,
    input  wire dual_half_timer_pkg::half_t cnt_wdata,
    input  wire logic                       cmp_wr,
    input  wire dual_half_timer_pkg::half_t cmp_wdata,
    output logic [7:0]                      count,
    output logic [7:0]                      compare,
    output logic                            ovf_ev,
    output logic                            match_ev
);
    logic [7:0] count_ff;       // Counter value.
    logic [7:0] nxt_count;      // Next counter value.
    logic [7:0] cmp_ff;         // Compare value.
    logic [7:0] nxt_cmp;        // Next compare value.
    logic [7:0] inc;            // Counter plus one.

    assign inc     = count_ff + 8'h01;
    assign count   = count_ff;
    assign compare = cmp_ff;

    // Count and compare updates, and the events they raise; a write beats the tick.
    always_comb begin
        nxt_count = count_ff;
        nxt_cmp   = cmp_ff;
        ovf_ev    = 1'b0;
        match_ev  = 1'b0;
        if (cnt_wr) begin
            nxt_count = cnt_wdata;  // A write in the wrap cycle hides the overflow.
        end else if (tick) begin
            nxt_count = inc;
            ovf_ev    = (count_ff == `DHT_HALF_MAX);
        end
        if (cmp_wr) begin
            nxt_cmp  = cmp_wdata;
            // The colliding match is dropped; equal new data matches at once.
            match_ev = run && (cmp_wdata == count_ff);
        end else begin
            // Matches only arise on the half's own tick, so none while stopped.
            match_ev = tick && !cnt_wr && (inc == cmp_ff);
        end
    end

    // Registers only; clock enable freezes them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= `DHT_COUNT_RST;
            cmp_ff   <= `DHT_COMPARE_RST;
        end else if (ce) begin
            count_ff <= nxt_count;
            cmp_ff   <= nxt_cmp;
        end
    end
endmodule
`default_nettype wire

/* File: src/dual_half_compare_timer.sv */
// Dual 8-bit or single 16-bit compare timer with toggle pins and an AXI4-Lite slave.
//
// How it works
// - 16-bit mode: upper flag on full overflow.
// - Counter write hides coinciding overflow.
// - Toggle pin inverts on each compare match.
// - Control write beats toggle, pin takes level.
// - Compare write drops match; equal data matches.
// - Match follows the half's counting clock.
// - Stopped counting clock gives no match.
// - Watch/4: irq pulse 1, events 2 periods.
// - Active mode: clear during irq pulse re-sets.
// - Ovf/match flag clear ignored while pulse stands.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dual_half_timer_map.svh"
module dual_half_compare_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        watch_clk_in,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             upper_toggle_pin,
    output logic             lower_toggle_pin
);
    // Bus slave state.
    logic        aw_got_ff;     // Write address held.
    logic        nxt_aw_got;
    logic [3:0]  awaddr_ff;     // Held write address.
    logic [3:0]  nxt_awaddr;
    logic        w_got_ff;      // Write data held.
    logic        nxt_w_got;
    logic [31:0] wdata_ff;      // Held write data.
    logic [31:0] nxt_wdata;
    logic [3:0]  wstrb_ff;      // Held byte strobes.
    logic [3:0]  nxt_wstrb;
    logic        bvalid_ff;     // Write response pending.
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;      // Write response code.
    logic [1:0]  nxt_bresp;
    logic        rvalid_ff;     // Read data pending.
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;      // Read data.
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;      // Read response code.
    logic [1:0]  nxt_rresp;
    logic        do_wr;         // Register write happens this cycle.
    logic        wr_ctrl;       // Byte 0 of the control register is written.
    logic        wr_stat;       // Status clear write.
    logic [1:0]  wr_cnt;        // Per-half counter write.
    logic [1:0]  wr_cmp;        // Per-half compare write.

    // Timer state.
    logic [`DHT_CTRL_W-1:0] ctrl_ff;    // timer_control_reg.
    logic [`DHT_CTRL_W-1:0] nxt_ctrl;
    logic [2:0]  wsync_ff;      // Watch clock: two sync stages plus edge history.
    logic [2:0]  nxt_wsync;
    logic [1:0]  wdiv_ff;       // Watch clock divide-by-four prescaler.
    logic [1:0]  nxt_wdiv;
    logic        w_tick;        // One cycle per watch clock rising edge.
    logic        w4_tick;       // One cycle per four watch periods.
    logic        mode16;        // Halves cascade into one 16-bit counter.
    logic        active;        // Active (high or medium speed) mode.
    logic [1:0]  sel_w4;        // Half counts on the divided watch clock.
    logic [1:0]  run;           // Half's counting clock is running.
    logic [1:0]  tick;          // Half's counting clock edge.
    logic [7:0]  count [2];     // Counter values, index 0 is the lower half.
    logic [7:0]  compare [2];   // Compare values.
    logic [1:0]  ovf_raw;       // Overflow events from the halves.
    logic [1:0]  match_ev;      // Compare match events.
    logic [1:0]  ovf_ev;        // Overflow events that may set their flag.
    logic [1:0]  ovf_flag;      // Overflow flags.
    logic [1:0]  cmf_flag;      // Match flags.
    logic [1:0]  irq_flag;      // Interrupt request flags.
    logic [1:0]  pin;           // Toggle pin levels.
    logic [1:0]  clk_sel [2];   // Counting clock selections.

    assign mode16     = ctrl_ff[`DHT_MODE16_BIT];
    assign active     = ctrl_ff[`DHT_ACTIVE_BIT];
    assign clk_sel[0] = ctrl_ff[`DHT_LO_CLKSEL_LSB +: 2];
    assign clk_sel[1] = ctrl_ff[`DHT_HI_CLKSEL_LSB +: 2];

    // The watch clock is a foreign pin: two stages before any logic looks at it.
    assign w_tick  = ce && wsync_ff[1] && !wsync_ff[2];
    assign w4_tick = w_tick && (wdiv_ff == 2'h3);

    // Watch clock synchroniser and prescaler.
    always_comb begin
        nxt_wsync = {wsync_ff[1:0], watch_clk_in};
        nxt_wdiv  = w_tick ? wdiv_ff + 2'h1 : wdiv_ff;
    end

    // Counting clocks. In 16-bit mode the upper half runs on the lower's carry.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            run[i]    = (clk_sel[0] != `DHT_CLK_STOP);
            sel_w4[i] = (clk_sel[0] == `DHT_CLK_W4);
        end
        tick[0] = ce && ((clk_sel[0] == `DHT_CLK_SYS) || (sel_w4[0] && w4_tick));
        if (mode16) begin
            tick[1] = ce && ovf_raw[0];
        end else begin
            run[1]    = (clk_sel[1] != `DHT_CLK_STOP);
            sel_w4[1] = (clk_sel[1] == `DHT_CLK_W4);
            tick[1]   = ce && ((clk_sel[1] == `DHT_CLK_SYS) || (sel_w4[1] && w4_tick));
        end
    end

    // Which events may set an overflow flag.
    always_comb begin
        ovf_ev[1] = ovf_raw[1];     // Full 16-bit overflow or 8-bit upper overflow.
        // In 16-bit mode the lower flag needs its own enable bit.
        ovf_ev[0] = ovf_raw[0] && (!mode16 || ctrl_ff[`DHT_LO_OVF16_BIT]);
    end

    // Per-half counter, pulse shaping, flags and toggle pin.
    for (genvar h = 0; h < 2; h++) begin : g_half
        logic [1:0] ovf_left_ff;    // Watch periods left of the overflow pulse.
        logic [1:0] nxt_ovf_left;
        logic [1:0] cmf_left_ff;    // Watch periods left of the match pulse.
        logic [1:0] nxt_cmf_left;
        logic       irq_left_ff;    // Watch period left of the interrupt source pulse.
        logic       nxt_irq_left;
        logic       ovf_ff;
        logic       nxt_ovf;
        logic       cmf_ff;
        logic       nxt_cmf;
        logic       irq_ff;
        logic       nxt_irq;
        logic       pin_ff;
        logic       nxt_pin;
        logic       ovf_pulse;      // Overflow signal.
        logic       cmf_pulse;      // Compare match signal.
        logic       irq_pulse;      // Interrupt source signal.
        logic       irq_ev;         // Start of an interrupt source pulse.

        half_counter u_half (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .ce        (ce),
            .tick      (tick[h]),
            .run       (run[h]),
            .cnt_wr    (wr_cnt[h]),
            .cnt_wdata (wdata_ff[8*h +: 8]),
            .cmp_wr    (wr_cmp[h]),
            .cmp_wdata (wdata_ff[8*h +: 8]),
            .count     (count[h]),
            .compare   (compare[h]),
            .ovf_ev    (ovf_raw[h]),
            .match_ev  (match_ev[h])
        );

        assign irq_ev    = ovf_ev[h] || match_ev[h];
        assign ovf_pulse = ovf_ev[h] || (ovf_left_ff != 2'h0);
        assign cmf_pulse = match_ev[h] || (cmf_left_ff != 2'h0);
        assign irq_pulse = irq_ev || irq_left_ff;

        // Stretch pulses on the divided watch clock; on the system clock they last one cycle.
        always_comb begin
            nxt_ovf_left = ovf_left_ff;
            nxt_cmf_left = cmf_left_ff;
            nxt_irq_left = irq_left_ff;
            if (w_tick) begin
                nxt_ovf_left = (ovf_left_ff != 2'h0) ? ovf_left_ff - 2'h1 : 2'h0;
                nxt_cmf_left = (cmf_left_ff != 2'h0) ? cmf_left_ff - 2'h1 : 2'h0;
                nxt_irq_left = 1'b0;
            end
            if (ovf_ev[h] && sel_w4[h]) begin
                nxt_ovf_left = `DHT_EVT_W_PERIODS;
            end
            if (match_ev[h] && sel_w4[h]) begin
                nxt_cmf_left = `DHT_EVT_W_PERIODS;
            end
            if (irq_ev && sel_w4[h]) begin
                nxt_irq_left = `DHT_IRQ_W_PERIODS;
            end
        end

        // Flags: setting wins over clearing; an overflow or match flag clear during a live pulse is ignored.
        always_comb begin
            nxt_ovf = ovf_ff;
            nxt_cmf = cmf_ff;
            nxt_irq = irq_ff;
            if (wr_stat && wdata_ff[`DHT_STAT_OVF_LSB + h] && !ovf_pulse) begin
                nxt_ovf = 1'b0;
            end
            if (wr_stat && wdata_ff[`DHT_STAT_CMF_LSB + h] && !cmf_pulse) begin
                nxt_cmf = 1'b0;
            end
            if (wr_stat && wdata_ff[`DHT_STAT_IRQ_LSB + h]) begin
                nxt_irq = 1'b0;
            end
            if (ovf_ev[h]) begin
                nxt_ovf = 1'b1;
            end
            if (match_ev[h]) begin
                nxt_cmf = 1'b1;
            end
            // In active mode the standing source pulse sets the flag again.
            if (irq_ev || (active && irq_pulse && irq_ff)) begin
                nxt_irq = 1'b1;
            end
        end

        // Toggle pin: a control write loads the level and beats a coinciding match.
        always_comb begin
            nxt_pin = pin_ff;
            if (wr_ctrl) begin
                nxt_pin = wdata_ff[`DHT_LEVEL_LSB + h];
            end else if (match_ev[h] && ctrl_ff[`DHT_TOGGLE_LSB + h]) begin
                nxt_pin = !pin_ff;
            end
        end

        // Registers of one half.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ovf_left_ff <= 2'h0;
                cmf_left_ff <= 2'h0;
                irq_left_ff <= 1'b0;
                ovf_ff      <= 1'b0;
                cmf_ff      <= 1'b0;
                irq_ff      <= 1'b0;
                pin_ff      <= 1'b0;
            end else if (ce) begin
                ovf_left_ff <= nxt_ovf_left;
                cmf_left_ff <= nxt_cmf_left;
                irq_left_ff <= nxt_irq_left;
                ovf_ff      <= nxt_ovf;
                cmf_ff      <= nxt_cmf;
                irq_ff      <= nxt_irq;
                pin_ff      <= nxt_pin;
            end
        end

        assign ovf_flag[h] = ovf_ff;
        assign cmf_flag[h] = cmf_ff;
        assign irq_flag[h] = irq_ff;
        assign pin[h]      = pin_ff;
    end

    assign upper_toggle_pin = pin[1];
    assign lower_toggle_pin = pin[0];

    // AXI4-Lite slave.
    // Address and data are caught in either order; the write lands once both are held.
    assign s_axi_awready = ce && !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = ce && !w_got_ff && !bvalid_ff;
    assign s_axi_arready = ce && !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    assign do_wr   = ce && aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_ctrl = do_wr && (awaddr_ff == `DHT_CTRL_OFS) && wstrb_ff[0];
    assign wr_stat = do_wr && (awaddr_ff == `DHT_STATUS_OFS) && wstrb_ff[0];
    assign wr_cnt  = (do_wr && (awaddr_ff == `DHT_COUNT_OFS)) ? wstrb_ff[1:0] : 2'h0;
    assign wr_cmp  = (do_wr && (awaddr_ff == `DHT_COMPARE_OFS)) ? wstrb_ff[1:0] : 2'h0;

    // Write channel sequencing and control register update.
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_got  = w_got_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_ctrl   = ctrl_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = {s_axi_awaddr[3:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            // Every aligned word in the 16-byte window is mapped.
            nxt_bresp  = `DHT_RESP_OKAY;
            if (wr_ctrl) begin
                nxt_ctrl[7:0] = wdata_ff[7:0];
            end
            if ((awaddr_ff == `DHT_CTRL_OFS) && wstrb_ff[1]) begin
                nxt_ctrl[`DHT_CTRL_W-1:8] = wdata_ff[`DHT_CTRL_W-1:8];
            end
        end else if (s_axi_bready && bvalid_ff) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Read channel: data sampled at the address handshake.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `DHT_RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            unique case ({s_axi_araddr[3:2], 2'h0})
                `DHT_CTRL_OFS: begin
                    nxt_rdata[`DHT_CTRL_W-1:0] = ctrl_ff;
                end
                `DHT_COUNT_OFS: begin
                    nxt_rdata[15:0] = {count[1], count[0]};
                end
                `DHT_COMPARE_OFS: begin
                    nxt_rdata[15:0] = {compare[1], compare[0]};
                end
                default: begin
                    nxt_rdata[7:0] = {pin, irq_flag, cmf_flag, ovf_flag};
                end
            endcase
        end else if (s_axi_rready && rvalid_ff) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Shared registers: bus slave, control, watch clock path.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            w_got_ff  <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `DHT_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `DHT_RESP_OKAY;
            ctrl_ff   <= `DHT_CTRL_RST;
            wsync_ff  <= 3'h0;
            wdiv_ff   <= 2'h0;
        end else if (ce) begin
            aw_got_ff <= nxt_aw_got;
            awaddr_ff <= nxt_awaddr;
            w_got_ff  <= nxt_w_got;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
            ctrl_ff   <= nxt_ctrl;
            wsync_ff  <= nxt_wsync;
            wdiv_ff   <= nxt_wdiv;
        end
    end
endmodule
`default_nettype wire

/* File: tb/toggle_pin_load.sv */
// Load on the two toggle pins that counts every level change it sees.
`timescale 1ns/1ps
`default_nettype none
module toggle_pin_load (
    input  wire logic aclk,
    input  wire logic upper_toggle_pin,
    input  wire logic lower_toggle_pin,
    output var  int   up_toggles,
    output var  int   lo_toggles
);
    // Last levels seen; both pins leave reset low.
    logic up_last = 1'b0;
    logic lo_last = 1'b0;
    // Sampling on the system clock is enough, since the pins only change there.
    always @(posedge aclk) begin
        up_toggles <= up_toggles + int'(upper_toggle_pin != up_last);
        lo_toggles <= lo_toggles + int'(lower_toggle_pin != lo_last);
        up_last <= upper_toggle_pin;
        lo_last <= lower_toggle_pin;
    end
endmodule
`default_nettype wire

/* File: tb/dual_half_compare_timer_asserts.sv */
// Port-level checks of the dual half compare timer.
`timescale 1ns/1ps
`default_nettype none
module dual_half_compare_timer_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        upper_toggle_pin,
    input wire logic        lower_toggle_pin
);
    // Remembers whether the last accepted write was a control write with byte 0.
    logic       ctrl_wr_ff;
    logic [1:0] lvl_ff;
    // Capture at the address handshake; the bench offers data in the same cycle.
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            ctrl_wr_ff <= (s_axi_awaddr[3:2] == 2'h0) && s_axi_wstrb[0];
            lvl_ff     <= {s_axi_wdata[2], s_axi_wdata[1]};
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_ctrl_level: assert property ($rose(s_axi_bvalid) && ctrl_wr_ff |->
        {upper_toggle_pin, lower_toggle_pin} == lvl_ff) else $error("pin not at level bit");
    chk_freeze_pins: assert property (!ce |=>
        $stable({upper_toggle_pin, lower_toggle_pin})) else $error("pin moved while frozen");
    chk_reset_pins: assert property ($rose(aresetn) |->
        !upper_toggle_pin && !lower_toggle_pin) else $error("pin high after reset");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wready |=>
        !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    cover property ($changed(upper_toggle_pin));
    cover property ($rose(s_axi_bvalid) && ctrl_wr_ff);
    cover property (!ce);
endmodule
bind dual_half_compare_timer dual_half_compare_timer_asserts i_chk (.*);
`default_nettype wire

/* File: tb/dual_half_compare_timer_tb.sv */
// Self-checking bench for the dual half compare timer.
`timescale 1ns/1ps
`default_nettype none
module dual_half_compare_timer_tb;
    // Clock, bus and pin signals of the block.
    logic        aclk, aresetn, ce, watch_clk_in;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, upper_toggle_pin, lower_toggle_pin;
    int          err_count, check_count, cycles, up_toggles, lo_toggles, u0, l0;
    dual_half_compare_timer i_dut (.*);
    toggle_pin_load i_load (.*);
    // A 40 ns system clock.
    initial aclk = 1'b0;
    always #20 aclk = ~aclk;
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Ceiling far above the fewer than one thousand cycles the tests need.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Compares one value and reports a mismatch at once.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus write; address and data are released as each is taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // One bus read; the masked data is compared with the expected value.
    task automatic rd_check(input string nm, input logic [3:0] a, input logic [31:0] m,
                            input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        check(nm, s_axi_rdata & m, exp);
        s_axi_rready <= 1'b0;
    endtask
    // Rising edges on the watch clock, slow enough for the two-stage synchroniser.
    task automatic watch(input int n);
        repeat (n) begin
            @(posedge aclk);
            watch_clk_in <= 1'b1;
            repeat (4) @(posedge aclk);
            watch_clk_in <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    initial begin
        {aresetn, watch_clk_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        ce = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_check("ctrl", 4'h0, 32'h7FF, 32'h400);
        rd_check("count", 4'h4, 32'hFFFF, 32'h0);
        rd_check("compare", 4'h8, 32'hFFFF, 32'hFFFF);
        rd_check("status", 4'hC, 32'hFF, 32'h0);
        $display("test reset values done");
        // Upper half on the system clock; lower stopped with count equal to compare.
        wr(4'h8, 32'h1000, 4'h3);
        wr(4'h0, 32'h490, 4'h3);
        u0 = up_toggles;
        l0 = lo_toggles;
        repeat (600) @(posedge aclk);
        wr(4'h0, 32'h410, 4'h3);
        rd_check("status", 4'hC, 32'h3F, 32'h2A);
        check("lower toggles", lo_toggles - l0, 32'h0);
        check("upper toggles", 32'(up_toggles - u0 >= 2), 32'h1);
        wr(4'hC, 32'h3F, 4'h1);
        rd_check("status", 4'hC, 32'h3F, 32'h0);
        $display("test system clock done");
        // Lower half on watch/4 with no watch edges, so its pulses stand.
        wr(4'h4, 32'h5, 4'h1);
        wr(4'h0, 32'h448, 4'h3);
        wr(4'h8, 32'h5, 4'h1);
        rd_check("status", 4'hC, 32'hFF, 32'h54);
        wr(4'hC, 32'h3F, 4'h1);
        rd_check("status", 4'hC, 32'hFF, 32'h54);
        watch(1);
        wr(4'hC, 32'h3F, 4'h1);
        rd_check("status", 4'hC, 32'hFF, 32'h44);
        watch(2);
        wr(4'hC, 32'h3F, 4'h1);
        rd_check("status", 4'hC, 32'hFF, 32'h40);
        $display("test watch clock done");
        // Control writes load the pins from the level bits.
        wr(4'h0, 32'h448, 4'h3);
        rd_check("pins", 4'hC, 32'hC0, 32'h0);
        wr(4'h0, 32'h44E, 4'h3);
        rd_check("pins", 4'hC, 32'hC0, 32'hC0);
        @(posedge aclk);
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        $display("test pin levels done");
        // Sixteen-bit mode wraps from all ones; only the upper overflow flag sets.
        wr(4'h4, 32'hFFFF, 4'h3);
        wr(4'h0, 32'h441, 4'h3);
        watch(8);
        rd_check("overflow", 4'hC, 32'h3, 32'h2);
        $display("test sixteen bit done");
        report_and_stop();
    end
endmodule
`default_nettype wire
